// ### dbd_controller.sv
// dram bank decode, strobe sequencing and row/column address multiplexing
// assumes requests and configuration come from logic on clk; refresh elsewhere
module dbd_controller (
	input  wire logic        clk,               // system clock
	input  wire logic        nrst,              // synchronous reset, active low
	input  wire logic        xferStart,         // one-cycle transfer request
	input  wire logic [31:0] xferAddr,          // transfer address
	input  wire logic        xferWrite,         // 1 = write
	input  wire logic        xferSuper,         // 1 = supervisor
	input  wire logic        xferCode,          // 1 = code
	input  wire logic [1:0]  xferSize,          // operand size
	input  wire logic        xferExtMaster,     // 1 = external master
	input  wire logic [3:0]  pinFunctionSelect, // 1 = pin 24+i is address
	input  wire logic [127:0] chipSelectBase,   // 8 x 16 bits, cs0 lowest
	input  wire logic [127:0] chipSelectMask,   // 8 x 16 bits, 1 = ignore
	input  wire logic [7:0]  chipSelectEnable,  // 1 = chip select valid
	input  wire logic [14:0] dramBankBase0,     // bank 0 base bits 31..17
	input  wire logic [14:0] dramBankMask0,     // bank 0 mask bits 31..17
	input  wire logic [3:0]  dramAttrMask0,     // bank 0 class masks
	input  wire logic [1:0]  dramBankControl0,  // bank 0 read/write enables
	input  wire logic [1:0]  dramPageMode0,     // bank 0 page mode
	input  wire logic [1:0]  portWidthSelect0,  // bank 0 port width
	input  wire logic [1:0]  bankPageSizeSelect0, // bank 0 page size
	input  wire logic [14:0] dramBankBase1,     // bank 1 base bits 31..17
	input  wire logic [14:0] dramBankMask1,     // bank 1 mask bits 31..17
	input  wire logic [3:0]  dramAttrMask1,     // bank 1 class masks
	input  wire logic [1:0]  dramBankControl1,  // bank 1 read/write enables
	input  wire logic [1:0]  dramPageMode1,     // bank 1 page mode
	input  wire logic [1:0]  portWidthSelect1,  // bank 1 port width
	input  wire logic [1:0]  bankPageSizeSelect1, // bank 1 page size
	input  wire logic [1:0]  rowDelay,          // extra cycles row to column
	input  wire logic [1:0]  casWidth,          // column strobe cycles minus one
	input  wire logic        extMasterMuxEnable, // mux external master transfers
	output logic [27:0]      addrPins,          // address pins
	output logic [1:0]       rasN,              // row strobe per bank
	output logic             casN,              // column strobe
	output logic             dramWriteN,        // dram write, active low
	output logic [7:0]       chipSelectN,       // chip select strobes
	output logic             defaultActive,     // default memory transfer
	output logic             busy,              // transfer in progress
	output logic             xferDone           // one-cycle completion
);
	// ==========================================================
	// latched request
	logic [31:0] reqAddr;     // current beat address
	logic        reqWrite;    // direction
	logic        reqSuper;    // supervisor flag
	logic        reqCode;     // code flag
	logic [1:0]  reqSize;     // operand size
	logic        reqExt;      // external master flag

	// ==========================================================
	// decode results
	logic [7:0]  csHit;        // per chip select match
	logic [1:0]  bankHit;      // per bank match with permission
	logic        anyCs;        // some chip select matched
	logic [2:0]  csIndex;      // lowest matching chip select
	logic        selBank;      // selected bank after priority
	logic        selIsDram;    // a bank won

	// ==========================================================
	// sequencing state
	dbd_pkg::dbd_state_t state;   // controller state
	logic        curBank;         // bank of the current transfer
	logic [1:0]  beatsLeft;       // beats after the current one
	logic [1:0]  waitCount;       // strobe timing counter
	logic        pageOpen;        // a row is held open
	logic        openBank;        // bank holding the open row
	logic [27:0] openAddr;        // address that opened the row
	logic        rowLive;         // row strobe may be low
	// released for precharge and for non-dram transfers
	assign rowLive = (state == dbd_pkg::ST_ROW || pageOpen) &&
		state != dbd_pkg::ST_PRE && !(state == dbd_pkg::ST_DECODE && !selIsDram);

	// ==========================================================
	// current bank configuration
	logic [1:0]  curMode;     // page mode
	logic [1:0]  curPort;     // port width code
	logic [1:0]  curPage;     // page size code
	logic [1:0]  portShift;   // log2 of port bytes
	logic [1:0]  pageCode;    // page size code clamped
	logic        isBurst;     // operand wider than port
	logic        keepPage;    // hold row between beats
	logic        useMux;      // multiplex the column
	logic        samePage;    // request hits the open row
	logic [27:0] rawAddr;     // unmodified internal address
	logic [27:0] colAddr;     // column phase pin image

	// ==========================================================
	// column phase pin image per port and page size
	function automatic logic [27:0] colMux(input logic [27:0] ia,
		input logic [1:0] pg, input logic [1:0] sh);
		int top;
		int low;
		logic [27:0] r;
		top = dbd_pkg::COL_TOP_BASE + 2 * int'(pg) - int'(sh);
		low = top - 8 - int'(pg);
		r = ia;
		for (int p = dbd_pkg::COL_PIN_LOW; p < dbd_pkg::PIN_ADDR_BITS; p++) begin
			if (p > top) begin
				// pins above the column keep pairs of row bits for larger parts
				r[p] = ia[p - ((p - top - 1) % 2)];
			end else if (p >= low) begin
				// column bits packed downward from the top pin
				r[p] = ia[8 + int'(pg) - (top - p)];
			end
		end
		return r;
	endfunction

	// ==========================================================
	// chip select match, cs0 highest priority
	genvar g;
	generate
		for (g = 0; g < dbd_pkg::NUM_CS; g++) begin : g_cs
			assign csHit[g] = chipSelectEnable[g] &
				(((reqAddr[31:16] ^ chipSelectBase[g*16 +: 16]) &
				~chipSelectMask[g*16 +: 16]) == 16'h0000);
		end
	endgenerate

	// lowest index wins
	always_comb begin
		csIndex = 3'h0;
		for (int i = dbd_pkg::NUM_CS - 1; i >= 0; i--) begin
			if (csHit[i]) begin
				csIndex = 3'(i);
			end
		end
	end
	assign anyCs = |csHit;

	// ==========================================================
	// dram bank matches
	dbd_bank_match u_bank0 (
		.addrHigh    (reqAddr[31:17]),
		.bankBase    (dramBankBase0),
		.bankMask    (dramBankMask0),
		.attrMask    (dramAttrMask0),
		.bankControl (dramBankControl0),
		.xferWrite   (reqWrite),
		.xferSuper   (reqSuper),
		.xferCode    (reqCode),
		.bankHit     (bankHit[0])
	);

	dbd_bank_match u_bank1 (
		.addrHigh    (reqAddr[31:17]),
		.bankBase    (dramBankBase1),
		.bankMask    (dramBankMask1),
		.attrMask    (dramAttrMask1),
		.bankControl (dramBankControl1),
		.xferWrite   (reqWrite),
		.xferSuper   (reqSuper),
		.xferCode    (reqCode),
		.bankHit     (bankHit[1])
	);

	// banks only below all chip selects, bank 0 before bank 1
	assign selIsDram = ~anyCs & (|bankHit);
	assign selBank = ~bankHit[0];

	// ==========================================================
	// per-bank configuration of the transfer in hand
	always_comb begin
		if (state == dbd_pkg::ST_DECODE ? selBank : curBank) begin
			curMode = dramPageMode1;
			curPort = portWidthSelect1;
			curPage = bankPageSizeSelect1;
		end else begin
			curMode = dramPageMode0;
			curPort = portWidthSelect0;
			curPage = bankPageSizeSelect0;
		end
	end

	// port code 01 is 8-bit, 10 16-bit, else 32-bit
	always_comb begin
		case (curPort)
			dbd_pkg::PORT_8:  portShift = 2'h0;
			dbd_pkg::PORT_16: portShift = 2'h1;
			default:          portShift = 2'h2;
		endcase
	end

	// page code 00 512 byte, 01 1 KB, else 2 KB
	assign pageCode = (curPage == dbd_pkg::PAGE_512) ? dbd_pkg::PAGE_512 :
		(curPage == dbd_pkg::PAGE_1K) ? dbd_pkg::PAGE_1K : dbd_pkg::PAGE_2K;

	assign isBurst = reqSize > portShift;
	// fast page keeps rows; burst page only inside a split operand
	assign keepPage = (curMode == dbd_pkg::MODE_FAST) ||
		((curMode == dbd_pkg::MODE_BURST) && isBurst);
	// core always muxed; external master only when enabled
	assign useMux = ~reqExt | extMasterMuxEnable;
	assign rawAddr = reqAddr[27:0];
	assign colAddr = useMux ? colMux(rawAddr, pageCode, portShift) : rawAddr;
	// same row means equal above the page bits
	assign samePage = pageOpen && (openBank == selBank) &&
		(28'((rawAddr ^ openAddr) >> (9 + int'(pageCode))) == 28'h0000000);

	// ==========================================================
	// request capture and beat address advance
	always_ff @(posedge clk) begin
		if (!nrst) begin
			reqAddr  <= 32'h00000000;
			reqWrite <= 1'b0;
			reqSuper <= 1'b0;
			reqCode  <= 1'b0;
			reqSize  <= dbd_pkg::OP_BYTE;
			reqExt   <= 1'b0;
		end else if (state == dbd_pkg::ST_IDLE && xferStart) begin
			reqAddr  <= xferAddr;
			reqWrite <= xferWrite;
			reqSuper <= xferSuper;
			reqCode  <= xferCode;
			reqSize  <= xferSize;
			reqExt   <= xferExtMaster;
		end else if (state == dbd_pkg::ST_CAS && waitCount == 2'h0 &&
			beatsLeft != 2'h0) begin
			// next beat one port width further, ready before the end cycle
			reqAddr <= reqAddr + (32'h1 << portShift);
		end
	end

	// ==========================================================
	// main sequencer
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state     <= dbd_pkg::ST_IDLE;
			curBank   <= 1'b0;
			beatsLeft <= dbd_pkg::BEATS_RESET;
			waitCount <= 2'h0;
		end else begin
			case (state)
				dbd_pkg::ST_IDLE: begin
					if (xferStart) begin
						state <= dbd_pkg::ST_DECODE;
					end
				end
				dbd_pkg::ST_DECODE: begin
					curBank <= selBank;
					// beats beyond the first when the operand is split
					beatsLeft <= isBurst ?
						2'((3'h1 << (reqSize - portShift)) - 3'h1) : 2'h0;
					if (!selIsDram) begin
						state <= dbd_pkg::ST_STATIC;
					end else if (samePage && keepPage) begin
						state <= dbd_pkg::ST_COL;
					end else if (pageOpen) begin
						state <= dbd_pkg::ST_PRE;
					end else begin
						state <= dbd_pkg::ST_ROW;
					end
					waitCount <= rowDelay;
				end
				dbd_pkg::ST_PRE: begin
					// row strobe high one cycle before a new row
					state <= dbd_pkg::ST_ROW;
				end
				dbd_pkg::ST_ROW: begin
					// common timing for both banks
					if (waitCount == 2'h0) begin
						state <= dbd_pkg::ST_COL;
					end else begin
						waitCount <= waitCount - 2'h1;
					end
				end
				dbd_pkg::ST_COL: begin
					state     <= dbd_pkg::ST_CAS;
					waitCount <= casWidth;
				end
				dbd_pkg::ST_CAS: begin
					if (waitCount == 2'h0) begin
						state <= dbd_pkg::ST_END;
					end else begin
						waitCount <= waitCount - 2'h1;
					end
				end
				dbd_pkg::ST_END: begin
					waitCount <= rowDelay;
					if (beatsLeft == 2'h0) begin
						state <= dbd_pkg::ST_IDLE;
					end else begin
						beatsLeft <= beatsLeft - 2'h1;
						// kept rows go straight to the next column
						state <= keepPage ? dbd_pkg::ST_COL : dbd_pkg::ST_PRE;
					end
				end
				dbd_pkg::ST_STATIC: begin
					state <= dbd_pkg::ST_IDLE;
				end
				default: begin
					state <= dbd_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// open row bookkeeping
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pageOpen <= 1'b0;
			openBank <= 1'b0;
			openAddr <= dbd_pkg::ADDR_RESET;
		end else if (state == dbd_pkg::ST_PRE ||
			(state == dbd_pkg::ST_DECODE && !selIsDram)) begin
			// precharge, or a non-dram transfer that must see no row strobe
			pageOpen <= 1'b0;
		end else if (state == dbd_pkg::ST_ROW) begin
			pageOpen <= 1'b1;
			openBank <= curBank;
			openAddr <= rawAddr;
		end else if (state == dbd_pkg::ST_END && !(keepPage &&
			(beatsLeft != 2'h0 || curMode == dbd_pkg::MODE_FAST))) begin
			// normal and finished burst transfers release the row
			pageOpen <= 1'b0;
		end
	end

	// ==========================================================
	// address pins
	always_ff @(posedge clk) begin
		if (!nrst) begin
			addrPins <= dbd_pkg::ADDR_RESET;
		end else begin
			logic [27:0] nextPins;
			nextPins = addrPins;
			if (state == dbd_pkg::ST_DECODE) begin
				// row image, or the column image at once on a page hit
				nextPins = (selIsDram && samePage && keepPage) ? colAddr : rawAddr;
			end else if (state == dbd_pkg::ST_END) begin
				// kept row: next column set up ahead of its strobe
				nextPins = (keepPage && beatsLeft != 2'h0) ? colAddr : rawAddr;
			end else if (state == dbd_pkg::ST_PRE) begin
				nextPins = rawAddr;
			end else if (state == dbd_pkg::ST_ROW && waitCount == 2'h0) begin
				// column image ahead of the column strobe
				nextPins = colAddr;
			end else if (state == dbd_pkg::ST_COL || state == dbd_pkg::ST_CAS) begin
				nextPins = colAddr;
			end
			// upper pins carry address only when selected as address
			nextPins[27:24] = nextPins[27:24] & pinFunctionSelect;
			addrPins <= nextPins;
		end
	end

	// ==========================================================
	// strobes
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rasN       <= 2'h3;
			casN       <= 1'b1;
			dramWriteN <= 1'b1;
		end else begin
			// row strobe follows the open row of its bank
			rasN[0] <= ~(rowLive && (state == dbd_pkg::ST_ROW ? ~curBank : ~openBank));
			rasN[1] <= ~(rowLive && (state == dbd_pkg::ST_ROW ? curBank : openBank));
			casN <= ~(state == dbd_pkg::ST_COL ||
				(state == dbd_pkg::ST_CAS && waitCount != 2'h0));
			dramWriteN <= ~(reqWrite && (state == dbd_pkg::ST_COL ||
				state == dbd_pkg::ST_CAS));
		end
	end

	// ==========================================================
	// chip select and default memory signalling
	always_ff @(posedge clk) begin
		if (!nrst) begin
			chipSelectN   <= 8'hff;
			defaultActive <= 1'b0;
		end else begin
			chipSelectN   <= 8'hff;
			defaultActive <= 1'b0;
			if (state == dbd_pkg::ST_DECODE && anyCs) begin
				chipSelectN[csIndex] <= 1'b0;
			end else if (state == dbd_pkg::ST_DECODE && !selIsDram) begin
				// no strobe of any kind on default memory
				defaultActive <= 1'b1;
			end
		end
	end

	// ==========================================================
	// status
	always_ff @(posedge clk) begin
		if (!nrst) begin
			busy     <= 1'b0;
			xferDone <= 1'b0;
		end else begin
			busy <= (state != dbd_pkg::ST_IDLE) || xferStart;
			xferDone <= (state == dbd_pkg::ST_STATIC) ||
				(state == dbd_pkg::ST_END && beatsLeft == 2'h0);
		end
	end
endmodule

// ### dbd_pkg.sv
// constants and types shared by the dram bank decoder and address mux
// assumes one clock domain; all configuration arrives as plain ports
package dbd_pkg;

	// ==========================================================
	// address widths
	localparam int PIN_ADDR_BITS  = 28;   // address pins driven
	localparam int CMP_HIGH       = 31;   // top compare bit
	localparam int CMP_LOW        = 17;   // lowest dram compare bit
	localparam int CMP_BITS       = 15;   // bits 31..17
	localparam int CS_LOW         = 16;   // lowest chip select compare bit
	localparam int CS_BITS        = 16;   // bits 31..16
	localparam int NUM_CS         = 8;    // chip selects 0..7
	localparam int CFG_PIN_LOW    = 24;   // first configurable pin
	localparam int COL_PIN_LOW    = 9;    // lowest muxed address pin
	localparam int COL_TOP_BASE   = 17;   // column top pin for 8-bit 512 byte

	// ==========================================================
	// field encodings
	localparam logic [1:0] PORT_32 = 2'h0;   // 32-bit port
	localparam logic [1:0] PORT_8  = 2'h1;   // 8-bit port
	localparam logic [1:0] PORT_16 = 2'h2;   // 16-bit port
	localparam logic [1:0] PAGE_512 = 2'h0;  // 512 byte page
	localparam logic [1:0] PAGE_1K  = 2'h1;  // 1 KB page
	localparam logic [1:0] PAGE_2K  = 2'h2;  // 2 KB page
	localparam logic [1:0] OP_BYTE = 2'h0;   // operand sizes
	localparam logic [1:0] OP_WORD = 2'h1;
	localparam logic [1:0] OP_LONG = 2'h2;
	localparam logic [1:0] CTRL_READ_ONLY  = 2'h1;  // control value for read only
	localparam logic [1:0] CTRL_READ_WRITE = 2'h3;  // control value for read/write

	// attribute mask bit positions
	localparam int ATTR_SUP_DATA  = 0;
	localparam int ATTR_SUP_CODE  = 1;
	localparam int ATTR_USER_DATA = 2;
	localparam int ATTR_USER_CODE = 3;

	// page modes
	typedef enum logic [1:0] {
		MODE_NORMAL = 2'b00,
		MODE_FAST   = 2'b01,
		MODE_BURST  = 2'b10
	} dbd_mode_t;

	// controller states
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_DECODE = 3'b001,
		ST_PRE    = 3'b010,
		ST_ROW    = 3'b011,
		ST_COL    = 3'b100,
		ST_CAS    = 3'b101,
		ST_END    = 3'b110,
		ST_STATIC = 3'b111
	} dbd_state_t;

	// reset values
	localparam logic [27:0] ADDR_RESET = 28'h0000000;
	localparam logic [1:0]  BEATS_RESET = 2'h0;
endpackage

// ### dbd_bank_match.sv
// permission-checked address match for one dram bank
// assumes transfer attributes are stable while they are compared
module dbd_bank_match (
	input  wire logic [14:0] addrHigh,       // transfer address bits 31..17
	input  wire logic [14:0] bankBase,       // dram_bank_base field
	input  wire logic [14:0] bankMask,       // base_address_mask_field, 1 = ignore
	input  wire logic [3:0]  attrMask,       // 1 = class excluded
	input  wire logic [1:0]  bankControl,    // bit0 read enable, bit1 write enable
	input  wire logic        xferWrite,      // 1 = write transfer
	input  wire logic        xferSuper,      // 1 = supervisor
	input  wire logic        xferCode,       // 1 = code fetch
	output logic             bankHit         // all three checks pass
);
	// ==========================================================
	// individual checks
	logic addrOk;     // unmasked bits equal
	logic dirOk;      // direction enabled
	logic attrOk;     // class not masked
	logic [1:0] cls;  // attribute class index

	// masked bits drop out of the compare
	assign addrOk = ((addrHigh ^ bankBase) & ~bankMask) == 15'h0000;
	// read needs bit0, write needs bit1; 01 read only, 11 read/write
	assign dirOk = xferWrite ? bankControl[1] : bankControl[0];
	// class index: super data, super code, user data, user code
	assign cls = {~xferSuper, xferCode};
	assign attrOk = ~attrMask[cls];
	// a failed check simply reads as no match
	assign bankHit = addrOk & dirOk & attrOk;
endmodule

// ### dbd_controller_asserts.sv
// checker for the dram bank decoder: strobe, pulse and pin relations
// assumes it is bound into dbd_controller and sees only its ports
module dbd_controller_chk (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic [3:0]  pinFunctionSelect,
	input wire logic [27:0] addrPins,
	input wire logic [1:0]  rasN,
	input wire logic        casN,
	input wire logic [7:0]  chipSelectN,
	input wire logic        defaultActive,
	input wire logic        xferDone
);
	// ==========================================================
	// one clock domain, reset disables every check
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// ==========================================================
	// decode outcome: one winner, then completion
	a_cs_single: assert property ($onehot0(~chipSelectN))
		else $error("two chip selects low");
	a_cs_then_done: assert property (chipSelectN != 8'hff |=> xferDone && chipSelectN == 8'hff)
		else $error("chip select not one cycle before done");
	a_cs_no_cas: assert property (chipSelectN != 8'hff |-> casN && rasN == 2'h3)
		else $error("column strobe during chip select");
	a_default_quiet: assert property (defaultActive |->
		casN && rasN == 2'h3 && chipSelectN == 8'hff)
		else $error("strobe during default transfer");
	a_default_done: assert property (defaultActive |=> xferDone && !defaultActive)
		else $error("default transfer not done next cycle");
	// ==========================================================
	// dram strobes and pins
	a_one_bank: assert property ($onehot0(~rasN))
		else $error("both row strobes low");
	a_cas_after_row: assert property ($fell(casN) |-> rasN != 2'h3 && $past(rasN) != 2'h3)
		else $error("column strobe without row");
	a_upper_pins: assert property (!casN |-> (addrPins[27:24] & ~pinFunctionSelect) == 4'h0)
		else $error("unselected upper pin driven");
endmodule

bind dbd_controller dbd_controller_chk u_chk (.*);

// ### dbd_dram_model.sv
// behavioural dram on the shared address pins, 9 address inputs
// assumes address is set up one cycle before each strobe falls
module dbd_dram_model (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic [27:0] addrPins,
	input wire logic [1:0]  rasN,
	input wire logic        casN,
	output logic [27:0]     rowPins,
	output logic [8:0]      rowAddr,
	output logic [8:0]      colAddr,
	output logic [7:0]      rasFalls,
	output logic [7:0]      casFalls
);
	logic [27:0] prevAddr;   // pins one cycle back
	logic        prevRas;    // both row strobes were high
	logic        prevCas;    // column strobe one cycle back
	// latch row and column on strobe falls, address inputs on A9..A17
	// pins below A9 are left unconnected on the board
	always_ff @(posedge clk) begin
		prevAddr <= addrPins;
		prevRas <= &rasN;
		prevCas <= casN;
		if (!nrst) begin
			rasFalls <= 8'h00;
			casFalls <= 8'h00;
		end
		if (prevRas && !(&rasN)) begin
			rowPins <= prevAddr;
			rowAddr <= prevAddr[17:9];
			rasFalls <= rasFalls + 8'h01;
		end
		if (prevCas && !casN) begin
			colAddr <= prevAddr[17:9];
			casFalls <= casFalls + 8'h01;
		end
	end
endmodule

// ### tb_dbd.sv
// self-checking bench for dbd_controller with a dram model on the pins
// assumes the checker file is compiled alongside and binds itself
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
	$display("BAD %0t mismatch %h %h", $time, (a), (b)); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// stimulus and observed signals
	logic         clk, nrst, xferStart, xferWrite, xferSuper, xferCode, xferExtMaster, wrSeen;
	logic         extMasterMuxEnable, casN, dramWriteN, defaultActive, busy, xferDone, defSeen;
	logic [31:0]  xferAddr;
	logic [1:0]   xferSize, rowDelay, casWidth, rasN, rasSeen;
	logic [3:0]   pinFunctionSelect, dramAttrMask0, dramAttrMask1;
	logic [127:0] chipSelectBase, chipSelectMask;
	logic [7:0]   chipSelectEnable, chipSelectN, csSeen, rasFalls, casFalls, r0, c0;
	logic [14:0]  dramBankBase0, dramBankMask0, dramBankBase1, dramBankMask1;
	logic [1:0]   dramBankControl0, dramPageMode0, portWidthSelect0, bankPageSizeSelect0;
	logic [1:0]   dramBankControl1, dramPageMode1, portWidthSelect1, bankPageSizeSelect1;
	logic [27:0]  addrPins, rowPins;
	logic [8:0]   rowAddr, colAddr;
	int           failures, n_tests, lat;
	localparam logic [10:0] DEF = 11'h004;   // default memory, no strobes
	localparam logic [10:0] BK0 = 11'h001;   // row strobe of bank 0
	localparam logic [10:0] BK1 = 11'h002;   // row strobe of bank 1
	localparam logic [31:0] A0  = 32'h0403a5b7; // address inside bank 0
	dbd_controller DUT (.*);
	dbd_dram_model u_dram (.*);
	// ==========================================================
	// clock and watchdog
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		#40000;
		failures++;
		end_sim();
	end
	// ==========================================================
	// one transfer; kind is write, supervisor, code, external master
	task automatic xfer(input logic [31:0] a, input logic [3:0] k, input logic [1:0] sz);
		int i;
		@(negedge clk);
		{xferWrite, xferSuper, xferCode, xferExtMaster} = k;
		xferAddr = a;
		xferSize = sz;
		xferStart = 1'b1;
		{csSeen, defSeen, rasSeen} = 11'h0;
		wrSeen = 1'b0;
		r0 = rasFalls;
		c0 = casFalls;
		@(negedge clk);
		xferStart = 1'b0;
		for (i = 0; i < 80 && xferDone !== 1'b1; i++) begin
			@(posedge clk);
			#1;
			{csSeen, defSeen, rasSeen} = {csSeen, defSeen, rasSeen} | {~chipSelectN, defaultActive, ~rasN};
			wrSeen = wrSeen | ~dramWriteN;
		end
		lat = i;
		`CHK(xferDone, 1'b1)
		@(negedge clk);
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_priority();
		xfer(32'h10000040, 4'b0100, dbd_pkg::OP_BYTE);
		`CHK({csSeen, defSeen, rasSeen}, 11'h008)
		chipSelectEnable = 8'h88;
		xfer(32'h10000040, 4'b0100, dbd_pkg::OP_BYTE);
		`CHK({csSeen, defSeen, rasSeen}, 11'h040)
		chipSelectEnable = 8'h80;
		xfer(32'h04000100, 4'b0100, dbd_pkg::OP_BYTE);
		`CHK({csSeen, defSeen, rasSeen}, 11'h400)
		chipSelectEnable = 8'h00;
		xfer(32'h10000040, 4'b0100, dbd_pkg::OP_BYTE);
		`CHK({csSeen, defSeen, rasSeen}, DEF)
	endtask
	task automatic t_perm();
		xfer(32'h04000000, 4'b0000, dbd_pkg::OP_BYTE);
		`CHK({csSeen, defSeen, rasSeen}, DEF)
		xfer(32'h04000000, 4'b1100, dbd_pkg::OP_BYTE);
		`CHK({csSeen, defSeen, rasSeen}, BK0)
		`CHK(wrSeen, 1'b1)
		xfer(32'h05000000, 4'b1000, dbd_pkg::OP_BYTE);
		`CHK({csSeen, defSeen, rasSeen}, DEF)
		`CHK(wrSeen, 1'b0)
		xfer(32'h05000000, 4'b0000, dbd_pkg::OP_BYTE);
		`CHK({csSeen, defSeen, rasSeen}, BK1)
		for (int k = 0; k < 4; k++)
			for (int c = 0; c < 4; c++) begin
				dramAttrMask0 = 4'h1 << k;
				xfer(32'h04000000, {1'b0, c < 2, c[0], 1'b0}, dbd_pkg::OP_BYTE);
				`CHK({csSeen, defSeen, rasSeen}, (c == k) ? DEF : BK0)
			end
		dramAttrMask0 = 4'hc;
		dramBankBase1 = 15'h0200;
		dramBankMask1 = 15'h007f;
		xfer(32'h04000000, 4'b0000, dbd_pkg::OP_BYTE);
		`CHK({csSeen, defSeen, rasSeen}, BK1)
		dramBankBase1 = 15'h0280;
		dramBankMask1 = 15'h0007;
	endtask
	task automatic t_mux();
		xfer(A0, 4'b0100, dbd_pkg::OP_BYTE);
		`CHK(rowPins, {2'h0, A0[25:0]})
		`CHK(rowAddr, A0[17:9])
		`CHK(colAddr, A0[8:0])
		xfer(A0, 4'b0101, dbd_pkg::OP_BYTE);
		`CHK(colAddr, A0[17:9])
		extMasterMuxEnable = 1'b1;
		xfer(A0, 4'b0101, dbd_pkg::OP_BYTE);
		`CHK(colAddr, A0[8:0])
		bankPageSizeSelect0 = dbd_pkg::PAGE_1K;
		xfer(A0, 4'b0100, dbd_pkg::OP_BYTE);
		`CHK(colAddr, {A0[7:0], A0[9]})
		bankPageSizeSelect0 = dbd_pkg::PAGE_512;
		portWidthSelect0 = dbd_pkg::PORT_16;
		xfer(A0, 4'b0100, dbd_pkg::OP_WORD);
		`CHK(colAddr, {A0[17], A0[8:1]})
		portWidthSelect0 = dbd_pkg::PORT_8;
	endtask
	// one strobe timing for both banks: 5 + rowDelay + casWidth edges
	task automatic t_timing();
		{rowDelay, casWidth} = 4'h6;
		xfer(32'h04000000, 4'b0100, dbd_pkg::OP_BYTE);
		`CHK(lat, 8)
		xfer(32'h05000000, 4'b0000, dbd_pkg::OP_BYTE);
		`CHK(lat, 8)
		{rowDelay, casWidth} = 4'h0;
	endtask
	task automatic t_modes();
		xfer(32'h04000010, 4'b0100, dbd_pkg::OP_LONG);
		`CHK({rasFalls - r0, casFalls - c0}, 16'h0404)
		dramPageMode0 = dbd_pkg::MODE_BURST;
		xfer(32'h04000010, 4'b0100, dbd_pkg::OP_LONG);
		`CHK({rasFalls - r0, casFalls - c0}, 16'h0104)
		`CHK(colAddr, 9'h013)
		xfer(32'h04000010, 4'b0100, dbd_pkg::OP_BYTE);
		xfer(32'h04000011, 4'b0100, dbd_pkg::OP_BYTE);
		`CHK({rasFalls - r0, casFalls - c0}, 16'h0101)
		dramPageMode0 = dbd_pkg::MODE_FAST;
		xfer(32'h04000010, 4'b0100, dbd_pkg::OP_BYTE);
		xfer(32'h04000011, 4'b0100, dbd_pkg::OP_BYTE);
		`CHK({rasFalls - r0, casFalls - c0}, 16'h0001)
		`CHK(colAddr, 9'h011)
		xfer(32'h04000210, 4'b0100, dbd_pkg::OP_BYTE);
		`CHK({rasFalls - r0, rowAddr}, {8'h01, 9'h001})
		xfer(32'h10000040, 4'b0100, dbd_pkg::OP_BYTE);
		`CHK({csSeen, defSeen, rasSeen}, DEF)
	endtask
	// ==========================================================
	// main sequence
	initial begin
		{nrst, xferStart, xferWrite, xferSuper, xferCode, xferExtMaster} = 6'h0;
		{extMasterMuxEnable, xferAddr, xferSize, rowDelay, casWidth} = 39'h0;
		{failures, n_tests} = 64'h0;
		pinFunctionSelect = 4'h3;
		chipSelectBase = {16'h0400, 48'h0, 16'h1000, 32'h0, 16'h1000};
		chipSelectMask = 128'h0;
		chipSelectEnable = 8'h89;
		{dramBankBase0, dramBankMask0, dramAttrMask0} = {15'h0200, 15'h007f, 4'hc};
		{dramBankBase1, dramBankMask1, dramAttrMask1} = {15'h0280, 15'h0007, 4'h0};
		dramBankControl0 = dbd_pkg::CTRL_READ_WRITE;
		dramBankControl1 = dbd_pkg::CTRL_READ_ONLY;
		{dramPageMode0, dramPageMode1} = {dbd_pkg::MODE_NORMAL, dbd_pkg::MODE_NORMAL};
		{portWidthSelect0, portWidthSelect1} = {dbd_pkg::PORT_8, dbd_pkg::PORT_8};
		{bankPageSizeSelect0, bankPageSizeSelect1} = {dbd_pkg::PAGE_512, dbd_pkg::PAGE_512};
		repeat (10) @(negedge clk);
		`CHK({addrPins, rasN, casN, dramWriteN, chipSelectN, defaultActive, busy, xferDone},
			43'h00000007ff8)
		nrst = 1'b1;
		t_priority();
		t_perm();
		t_mux();
		t_timing();
		t_modes();
		end_sim();
	end
endmodule
